// ### verilog/ebi_host_seq.sv
/*
  Host-side cycle sequencer for the expansion bus: extended-space cycles
  (types A, C, stretched by the card's wait line) and DMA cycles (A-D).
  Assumes card inputs are synchronous to I_CLOCK (25 MHz).
*/
`timescale 1ns/100ps
`default_nettype none
`include "ebi_params.svh"
module ebi_host_seq #(
  parameter int DATA_W = `EBI_DATA_W,
  parameter int ADDR_W = `EBI_ADDR_W,
  parameter int DEPTH  = `EBI_FIFO_DEPTH
) (
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST_N,
  // command side: one ext access request
  input  wire logic              i_ext_req,
  input  wire logic              i_ext_rd,
  input  wire logic              i_ext_byte,
  input  wire logic              i_ext_slow,
  input  wire logic [ADDR_W-1:0] i_ext_addr,
  input  wire logic [DATA_W-1:0] i_ext_wdata,
  output logic                   o_ext_busy,
  output logic                   o_ext_done,
  output logic [DATA_W-1:0]      o_ext_rdata,
  // DMA channel setup
  input  wire logic              i_dma_en,
  input  wire logic              i_dma_rd,
  input  wire logic [1:0]        i_dma_speed,
  input  wire logic [15:0]       i_dma_count,
  input  wire logic              i_dma_start,
  output logic                   o_dma_active,
  // DMA read data stream (card to memory), via FIFO
  output logic                   o_rx_valid,
  output logic [DATA_W-1:0]      o_rx_data,
  input  wire logic              i_rx_ready,
  // DMA write data stream (memory to card)
  input  wire logic [DATA_W-1:0] i_tx_data,
  // bus pins
  output logic [ADDR_W-1:0]      o_addr,
  output logic                   o_byte_width,
  output logic                   o_ext_sel_n,
  output logic                   o_io_rd_n,
  output logic                   o_io_wr_n,
  output logic                   o_rw_qual,
  output logic                   o_dma_ack_n,
  output logic                   o_term_count,
  input  wire logic              i_dma_request,
  input  wire logic              i_wait_n,
  input  wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0]      o_data,
  output logic [DATA_W-1:0]      o_data_oe
);
  // ****************************************
  // timing in clock cycles
  // ****************************************
  localparam logic [3:0] C_LEAD_A = 4'(`EBI_CYC(`EBI_LEAD_A_NS));
  localparam logic [3:0] C_LEAD_C = 4'(`EBI_CYC(`EBI_LEAD_C_NS));
  localparam logic [3:0] C_QUAL   = 4'(`EBI_CYC(`EBI_QUAL_NS));

  // strobe cycles; leads and trails fill the rest of the select width
  function automatic logic [3:0] stb_cyc(input logic dma, input ebi_pkg::ebi_speed_t s);
    logic [3:0] r;
    r = 4'(`EBI_CYC(`EBI_DMA_D_STB_NS));
    unique case (s)
      ebi_pkg::SPD_A: r = 4'(`EBI_CYC(`EBI_DMA_A_STB_NS));
      ebi_pkg::SPD_B: r = 4'(`EBI_CYC(`EBI_DMA_B_STB_NS));
      ebi_pkg::SPD_C: r = 4'(`EBI_CYC(`EBI_DMA_C_STB_NS));
      ebi_pkg::SPD_D: r = 4'(`EBI_CYC(`EBI_DMA_D_STB_NS));
    endcase
    return r;
  endfunction

  function automatic logic [3:0] sel_cyc(input logic dma, input ebi_pkg::ebi_speed_t s);
    logic [3:0] r;
    r = 4'(`EBI_CYC(`EBI_DMA_D_ACK_NS));
    unique case (s)
      ebi_pkg::SPD_A: r = 4'(`EBI_CYC(dma ? `EBI_DMA_A_ACK_NS : `EBI_EXT_A_SEL_NS));
      ebi_pkg::SPD_B: r = 4'(`EBI_CYC(`EBI_DMA_B_ACK_NS));
      ebi_pkg::SPD_C: r = 4'(`EBI_CYC(dma ? `EBI_DMA_C_ACK_NS : `EBI_EXT_C_SEL_NS));
      ebi_pkg::SPD_D: r = 4'(`EBI_CYC(`EBI_DMA_D_ACK_NS));
    endcase
    return r;
  endfunction

  function automatic logic [3:0] lead_cyc(input ebi_pkg::ebi_speed_t s);
    return (s == ebi_pkg::SPD_A || s == ebi_pkg::SPD_B) ? C_LEAD_A : C_LEAD_C;
  endfunction

  // ****************************************
  // state
  // ****************************************
  ebi_pkg::ebi_state_t st_r;
  ebi_pkg::ebi_speed_t spd_r;
  logic                dma_r;
  logic                rd_r;
  logic [3:0]          cnt_r;
  logic [3:0]          sel_left_r;
  logic [15:0]         left_r;
  logic                tx_v;
  logic                fifo_ready;

  ebi_fifo_if #(.W(DATA_W)) rx_in ();
  ebi_fifo_if #(.W(DATA_W)) rx_out ();

  ebi_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .wr      (rx_in),
    .rd      (rx_out)
  );

  assign fifo_ready   = rx_in.ready;
  assign rx_out.ready = i_rx_ready;
  assign tx_v         = 1'b1;

  // dma start gating: a read cycle waits for FIFO room so data is never dropped
  logic dma_go;
  assign dma_go = i_dma_en && (left_r != '0) && i_dma_request && (!i_dma_rd || fifo_ready);

  // ****************************************
  // sequencer
  // ****************************************
  // ext requests win over DMA when both wait in idle
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_r       <= ebi_pkg::ST_IDLE;
      spd_r      <= ebi_pkg::SPD_A;
      dma_r      <= 1'b0;
      rd_r       <= 1'b1;
      cnt_r      <= '0;
      sel_left_r <= '0;
    end else begin
      unique case (st_r)
        ebi_pkg::ST_IDLE: begin
          if (i_ext_req) begin
            dma_r <= 1'b0;
            rd_r  <= i_ext_rd;
            spd_r <= i_ext_slow ? ebi_pkg::SPD_A : ebi_pkg::SPD_C;
            cnt_r <= C_QUAL; // qualifier settles before select
            st_r  <= ebi_pkg::ST_GAP;
          end else if (dma_go) begin
            dma_r <= 1'b1;
            rd_r  <= i_dma_rd;
            spd_r <= ebi_pkg::ebi_speed_t'(i_dma_speed);
            cnt_r <= C_QUAL;
            st_r  <= ebi_pkg::ST_GAP;
          end
        end
        ebi_pkg::ST_GAP: begin
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            cnt_r      <= lead_cyc(spd_r);
            sel_left_r <= sel_cyc(dma_r, spd_r);
            st_r       <= ebi_pkg::ST_LEAD;
          end
        end
        ebi_pkg::ST_LEAD: begin
          sel_left_r <= sel_left_r - 4'h1;
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            cnt_r <= stb_cyc(dma_r, spd_r);
            st_r  <= ebi_pkg::ST_STROBE;
          end
        end
        ebi_pkg::ST_STROBE: begin
          if (sel_left_r != '0) begin
            sel_left_r <= sel_left_r - 4'h1;
          end
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (!dma_r && !i_wait_n) begin
            st_r <= ebi_pkg::ST_STRETCH;
          end else begin
            cnt_r <= lead_cyc(spd_r);
            st_r  <= ebi_pkg::ST_TRAIL;
          end
        end
        ebi_pkg::ST_STRETCH: begin
          if (i_wait_n) begin // hold strobe until card releases wait
            cnt_r <= lead_cyc(spd_r);
            st_r  <= ebi_pkg::ST_TRAIL;
          end
        end
        ebi_pkg::ST_TRAIL: begin
          if (sel_left_r != '0) begin
            sel_left_r <= sel_left_r - 4'h1;
          end
          // select stays low until both trail and total width are met
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (sel_left_r <= 4'h1) begin
            cnt_r <= C_QUAL; // count goes unused: idle starts the next cycle at once, so the qualifier can change as select rises
            st_r  <= ebi_pkg::ST_IDLE;
          end
        end
        default: st_r <= ebi_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // bus pin drive, all registered
  // ****************************************
  logic sel_phase;
  logic stb_phase;
  assign sel_phase = (st_r == ebi_pkg::ST_LEAD) || (st_r == ebi_pkg::ST_STROBE) ||
                     (st_r == ebi_pkg::ST_STRETCH) || (st_r == ebi_pkg::ST_TRAIL);
  assign stb_phase = (st_r == ebi_pkg::ST_STROBE) || (st_r == ebi_pkg::ST_STRETCH);

  // pins lag state by one cycle; qualifier gap states cover that lag
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_ext_sel_n  <= 1'b1;
      o_dma_ack_n  <= 1'b1;
      o_io_rd_n    <= 1'b1;
      o_io_wr_n    <= 1'b1;
      o_term_count <= 1'b0;
      o_rw_qual    <= 1'b1;
      o_byte_width <= 1'b1;
      o_addr       <= '0;
    end else begin
      o_ext_sel_n  <= !(sel_phase && !dma_r);
      o_dma_ack_n  <= !(sel_phase && dma_r);
      o_io_rd_n    <= !(stb_phase && rd_r);
      o_io_wr_n    <= !(stb_phase && !rd_r);
      o_term_count <= sel_phase && dma_r && (left_r == 16'h0001);
      if (st_r == ebi_pkg::ST_IDLE && i_ext_req) begin
        o_rw_qual    <= i_ext_rd;
        o_byte_width <= !i_ext_byte;
        o_addr       <= i_ext_addr;
      end else if (st_r == ebi_pkg::ST_IDLE && dma_go) begin
        o_rw_qual <= i_dma_rd;
      end
    end
  end

  // write data drive; host leaves all lines free during reads
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_data    <= '0;
      o_data_oe <= '1; // host drives while idle
    end else begin
      o_data_oe <= (sel_phase && rd_r) ? '0 : '1;
      if (st_r == ebi_pkg::ST_IDLE && i_ext_req) begin
        o_data <= i_ext_wdata;
      end else if (st_r == ebi_pkg::ST_IDLE && dma_go && tx_v) begin
        o_data <= i_tx_data;
      end
    end
  end

  // ****************************************
  // transfer count and read capture
  // ****************************************
  logic cyc_end;
  assign cyc_end = (st_r == ebi_pkg::ST_TRAIL) && (cnt_r <= 4'h1) && (sel_left_r <= 4'h1);

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      left_r <= '0;
    end else if (i_dma_start) begin
      left_r <= i_dma_count;
    end else if (cyc_end && dma_r && left_r != '0) begin
      left_r <= left_r - 16'h0001;
    end
  end

  // capture read data in the strobe's last cycle, one clock before the strobe pin rises
  logic strobe_end;
  assign strobe_end = (st_r == ebi_pkg::ST_STROBE && cnt_r <= 4'h1 && (dma_r || i_wait_n)) ||
                      (st_r == ebi_pkg::ST_STRETCH && i_wait_n);
  assign rx_in.valid = strobe_end && dma_r && rd_r;
  assign rx_in.data  = i_data;

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_ext_rdata  <= '0;
      o_ext_done   <= 1'b0;
      o_ext_busy   <= 1'b0;
      o_dma_active <= 1'b0;
      o_rx_valid   <= 1'b0;
      o_rx_data    <= '0;
    end else begin
      if (strobe_end && !dma_r && rd_r) begin
        o_ext_rdata <= i_data;
      end
      o_ext_done   <= cyc_end && !dma_r;
      o_ext_busy   <= (st_r != ebi_pkg::ST_IDLE) || i_ext_req;
      o_dma_active <= (left_r != '0);
      o_rx_valid   <= rx_out.valid;
      o_rx_data    <= rx_out.data;
    end
  end
endmodule
`default_nettype wire

// ### verilog/ebi_params.svh
/*
  Timing constants and data path sizes for the host-side expansion bus
  cycle sequencer. Assumes inclusion by bare name from verilog/.
*/
`ifndef EBI_PARAMS_SVH
`define EBI_PARAMS_SVH

// ****************************************
// clock and strobe timing
// ****************************************
`define EBI_CLK_NS        40
// least times round up to whole clock cycles
`define EBI_CYC(ns)       (((ns) + `EBI_CLK_NS - 1) / `EBI_CLK_NS)

`define EBI_EXT_A_SEL_NS  427
`define EBI_EXT_C_SEL_NS  175
`define EBI_EXT_A_STB_NS  240
`define EBI_EXT_C_STB_NS  115
`define EBI_DMA_A_ACK_NS  427
`define EBI_DMA_B_ACK_NS  302
`define EBI_DMA_C_ACK_NS  175
`define EBI_DMA_D_ACK_NS  115
`define EBI_DMA_A_STB_NS  240
`define EBI_DMA_B_STB_NS  175
`define EBI_DMA_C_STB_NS  115
`define EBI_DMA_D_STB_NS  52
`define EBI_LEAD_A_NS     80
`define EBI_LEAD_C_NS     15
`define EBI_QUAL_NS       10

// ****************************************
// data path
// ****************************************
`define EBI_DATA_W        32
`define EBI_ADDR_W        24
`define EBI_FIFO_DEPTH    8

`endif

// ### verilog/ebi_pkg.sv
/*
  Types used by the sequencer; its FIFO does not use them.
  Assumes nothing outside itself.
*/
package ebi_pkg;
  // cycle speed: ext cycles use A and C only
  typedef enum logic [1:0] {
    SPD_A,
    SPD_B,
    SPD_C,
    SPD_D
  } ebi_speed_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_STROBE,
    ST_STRETCH,
    ST_TRAIL,
    ST_GAP
  } ebi_state_t;
endpackage

// ### verilog/ebi_fifo_if.sv
/*
  Valid/ready stream interface between the sequencer and its FIFO.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface ebi_fifo_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### verilog/ebi_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides; read data from a register.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ebi_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  ebi_fifo_if.snk   wr,
  ebi_fifo_if.src   rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          out_v_r;
  logic [W-1:0]  out_d_r;
  logic          push;
  logic          pop_mem;

  // out register refills from memory whenever it is empty or being drained and memory holds a word
  assign wr.ready = ((cnt_r + (AW+1)'(out_v_r)) != DEPTH[AW:0]); // out word counts too
  assign push     = wr.valid && wr.ready;
  assign pop_mem  = (cnt_r != '0) && (!out_v_r || rd.ready);
  assign rd.valid = out_v_r;
  assign rd.data  = out_d_r;

  // storage, no reset needed on the array
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop_mem) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop_mem);
    end
  end

  // registered output word
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_v_r <= 1'b0;
      out_d_r <= '0;
    end else if (pop_mem) begin
      out_v_r <= 1'b1;
      out_d_r <= mem[rp_r];
    end else if (rd.ready) begin
      out_v_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/ebi_host_seq_monitor.sv
/*
  Concurrent checks on the sequencer's bus pins, bound to its top.
  Assumes command inputs stay steady while a cycle runs.
*/
`timescale 1ns/100ps
`default_nettype none
module ebi_host_seq_monitor #(
  parameter int DATA_W = 32
) (
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST_N,
  input  wire logic              i_ext_slow,
  input  wire logic              i_ext_byte,
  input  wire logic              i_dma_rd,
  input  wire logic [1:0]        i_dma_speed,
  input  wire logic              o_byte_width,
  input  wire logic              o_ext_sel_n,
  input  wire logic              o_io_rd_n,
  input  wire logic              o_io_wr_n,
  input  wire logic              o_rw_qual,
  input  wire logic              o_dma_ack_n,
  input  wire logic              o_term_count,
  input  wire logic [DATA_W-1:0] o_data_oe
);
  // ****************************************
  // low-time counters
  // ****************************************
  localparam int ACK_MIN [4] = '{11, 8, 5, 3};
  localparam int STB_MIN [4] = '{6, 5, 3, 2};
  logic [4:0] sel_cnt_r;
  logic [4:0] ack_cnt_r;
  logic [4:0] stb_cnt_r;

  // saturating, so a long stretch cannot wrap under a minimum
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sel_cnt_r <= 5'h00;
      ack_cnt_r <= 5'h00;
      stb_cnt_r <= 5'h00;
    end else begin
      sel_cnt_r <= o_ext_sel_n ? 5'h00 : sel_cnt_r + {4'h0, ~&sel_cnt_r};
      ack_cnt_r <= o_dma_ack_n ? 5'h00 : ack_cnt_r + {4'h0, ~&ack_cnt_r};
      stb_cnt_r <= (o_io_rd_n & o_io_wr_n) ? 5'h00 : stb_cnt_r + {4'h0, ~&stb_cnt_r};
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  chk_ext_sel_width: assert property (
    $rose(o_ext_sel_n) |-> sel_cnt_r >= (i_ext_slow ? 5'h0B : 5'h05))
    else $error("ext select low too short");
  chk_dma_ack_width: assert property (
    $rose(o_dma_ack_n) |-> ack_cnt_r >= ACK_MIN[i_dma_speed])
    else $error("dma acknowledge low too short");
  chk_dma_stb_width: assert property (
    $rose(o_io_rd_n & o_io_wr_n) && !o_dma_ack_n |-> stb_cnt_r >= STB_MIN[i_dma_speed])
    else $error("dma strobe low too short");
  chk_tc_with_ack: assert property (
    $rose(o_term_count) |-> $fell(o_dma_ack_n))
    else $error("terminal count rose apart from acknowledge");
  chk_tc_inside_ack: assert property (
    o_term_count |-> !o_dma_ack_n)
    else $error("terminal count high outside acknowledge");
  chk_qual_setup: assert property (
    $fell(o_dma_ack_n) || $fell(o_ext_sel_n) |-> $stable(o_rw_qual))
    else $error("qualifier moved with select edge");
  chk_dma_dir: assert property (
    !o_dma_ack_n |-> o_rw_qual == i_dma_rd)
    else $error("qualifier disagrees with dma direction");
  chk_byte_width: assert property (
    $fell(o_ext_sel_n) |-> o_byte_width == !i_ext_byte)
    else $error("width indication wrong at select");
  chk_upper_release: assert property (
    (!o_ext_sel_n || !o_dma_ack_n) && o_rw_qual && !o_io_rd_n |-> o_data_oe[DATA_W-1:16] == 16'h0000)
    else $error("host drives upper lines during read");

  cov_ext_slow: cover property ($rose(o_ext_sel_n) && i_ext_slow);
  cov_dma_last: cover property ($rose(o_term_count));
  cov_dma_read: cover property ($fell(o_dma_ack_n) && o_rw_qual);
endmodule
bind ebi_host_seq ebi_host_seq_monitor #(.DATA_W(DATA_W)) u_mon (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .i_ext_slow(i_ext_slow), .i_ext_byte(i_ext_byte),
  .i_dma_rd(i_dma_rd), .i_dma_speed(i_dma_speed), .o_byte_width(o_byte_width),
  .o_ext_sel_n(o_ext_sel_n), .o_io_rd_n(o_io_rd_n), .o_io_wr_n(o_io_wr_n),
  .o_rw_qual(o_rw_qual), .o_dma_ack_n(o_dma_ack_n), .o_term_count(o_term_count),
  .o_data_oe(o_data_oe));
`default_nettype wire

// ### testbench/ebi_card_model.sv
/*
  Behavioural expansion card: dma requester, wait stretcher, data source.
  Assumes the bench resolves the shared data bus from both enables.
*/
`timescale 1ns/100ps
`default_nettype none
module ebi_card_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic [15:0] i_words,
  input  wire logic [3:0]  i_wait_len,
  input  wire logic [23:0] i_addr,
  input  wire logic        i_byte_width,
  input  wire logic        i_sel_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_qual,
  input  wire logic        i_ack_n,
  input  wire logic        i_tc,
  input  wire logic [31:0] i_bus,
  output logic             o_request,
  output logic             o_wait_n,
  output logic [31:0]      o_data,
  output logic [31:0]      o_oe,
  output logic [31:0]      o_wr_word,
  output logic [15:0]      o_wr_cnt,
  output logic [15:0]      o_acks,
  output logic [15:0]      o_tc_cnt
);
  logic [2:0]  ack_s_r;
  logic [15:0] left_r;
  logic [15:0] idx_r;
  logic [3:0]  wait_r;
  logic        waited_r;
  logic        wr_d_r;
  logic        ack_fall;
  assign ack_fall = ack_s_r[2] & ~ack_s_r[1];

  // ****************************************
  // request side, on the card's own clock
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_s_r   <= 3'h7;
      left_r    <= 16'h0000;
      idx_r     <= 16'h0000;
      o_acks    <= 16'h0000;
      o_tc_cnt  <= 16'h0000;
      o_request <= 1'b0;
    end else begin
      ack_s_r <= {ack_s_r[1:0], i_ack_n};
      if (i_start) begin
        left_r <= i_words;
        idx_r  <= 16'h0000;
        o_acks <= 16'h0000;
      end else begin
        if (ack_fall && left_r != 16'h0000) left_r <= left_r - 16'h0001;
        if (ack_fall) o_acks <= o_acks + 16'h0001;
        if (ack_fall && i_tc) o_tc_cnt <= o_tc_cnt + 16'h0001;
        if (i_ack_n && !ack_s_r[0]) idx_r <= idx_r + 16'h0001;
      end
      // raise only after acknowledge has been seen high for a while
      if (!o_request) o_request <= (left_r != 16'h0000) && ack_s_r[1] && !i_start;
      // held across back-to-back cycles, dropped once the last ack is seen
      else if (ack_fall && left_r == 16'h0001) o_request <= 1'b0;
    end
  end

  // stretch each ext cycle once, one cycle after the strobe falls
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r   <= 4'h0;
      waited_r <= 1'b0;
      o_wait_n <= 1'b1;
    end else if (i_sel_n) begin
      waited_r <= 1'b0;
      o_wait_n <= 1'b1;
    end else if (!(i_rd_n & i_wr_n) && !waited_r) begin
      waited_r <= 1'b1;
      wait_r   <= i_wait_len;
      o_wait_n <= (i_wait_len == 4'h0);
    end else if (wait_r > 4'h1) wait_r <= wait_r - 4'h1;
    else o_wait_n <= 1'b1;
  end

  // read lanes: direction from qualifier, byte reads on the low lane only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_oe      <= 32'h00000000;
      o_data    <= 32'h00000000;
      o_wr_word <= 32'h00000000;
      o_wr_cnt  <= 16'h0000;
      wr_d_r    <= 1'b1;
    end else begin
      o_oe <= (i_qual && !i_sel_n) ? (i_byte_width ? 32'hFFFFFFFF : 32'h000000FF) :
              (i_qual && !i_ack_n) ? 32'hFFFFFFFF : 32'h00000000;
      o_data <= !i_sel_n ? {8'hE5, i_addr} : {16'hD0A0, idx_r};
      wr_d_r <= i_wr_n;
      if (!i_wr_n) o_wr_word <= i_bus;
      if (i_wr_n && !wr_d_r) o_wr_cnt <= o_wr_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### testbench/test_ebi_host_seq.sv
/*
  Self-checking bench: ext and dma cycles against the card model.
  Assumes design, interface and fifo files compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ebi_params.svh"
module test_ebi_host_seq;
  logic        clk, rst_n, ext_req, ext_rd, ext_byte, ext_slow, ext_busy, ext_done;
  logic        dma_en, dma_rd, dma_start, dma_active, rx_valid, rx_ready, card_start;
  logic        byte_width, sel_n, rd_n, wr_n, qual, ack_n, tc, request, wait_n;
  logic [1:0]  dma_speed;
  logic [3:0]  wait_len;
  logic [15:0] dma_count, words, wr_cnt, acks, tc_cnt;
  logic [23:0] ext_addr, addr;
  logic [31:0] ext_wdata, ext_rdata, rx_data, tx_data, bus, host_data, host_oe;
  logic [31:0] card_data, card_oe, last_bus, wr_word, seed, r;
  int          miscompares, comparisons, cycles;

  // undriven lanes show the inverse of their last level, never a held value
  assign bus = (card_oe & card_data) | (~card_oe & host_oe & host_data) |
               (~card_oe & ~host_oe & ~last_bus);

  ebi_host_seq uut (.I_CLOCK(clk), .I_RST_N(rst_n), .i_ext_req(ext_req), .i_ext_rd(ext_rd),
    .i_ext_byte(ext_byte), .i_ext_slow(ext_slow), .i_ext_addr(ext_addr),
    .i_ext_wdata(ext_wdata), .o_ext_busy(ext_busy), .o_ext_done(ext_done),
    .o_ext_rdata(ext_rdata), .i_dma_en(dma_en), .i_dma_rd(dma_rd), .i_dma_speed(dma_speed),
    .i_dma_count(dma_count), .i_dma_start(dma_start), .o_dma_active(dma_active),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready), .i_tx_data(tx_data),
    .o_addr(addr), .o_byte_width(byte_width), .o_ext_sel_n(sel_n), .o_io_rd_n(rd_n),
    .o_io_wr_n(wr_n), .o_rw_qual(qual), .o_dma_ack_n(ack_n), .o_term_count(tc),
    .i_dma_request(request), .i_wait_n(wait_n), .i_data(bus), .o_data(host_data),
    .o_data_oe(host_oe));

  ebi_card_model u_card (.i_clk(clk), .i_rst_n(rst_n), .i_start(card_start), .i_words(words),
    .i_wait_len(wait_len), .i_addr(addr), .i_byte_width(byte_width), .i_sel_n(sel_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_qual(qual), .i_ack_n(ack_n), .i_tc(tc), .i_bus(bus),
    .o_request(request), .o_wait_n(wait_n), .o_data(card_data), .o_oe(card_oe),
    .o_wr_word(wr_word), .o_wr_cnt(wr_cnt), .o_acks(acks), .o_tc_cnt(tc_cnt));

  // ****************************************
  // clock, timeout and helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // cut a hang short well past the expected thousand or so cycles
  always @(posedge clk) begin
    last_bus <= bus;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] exp_ext(input logic [23:0] a);
    return {8'hE5, a};
  endfunction

  function automatic logic [31:0] exp_dma(input logic [15:0] i);
    return {16'hD0A0, i};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // transfers
  // ****************************************
  task automatic ext_cycle(input logic slow, rd, bw, input logic [3:0] wl);
    logic [31:0] m;
    int          g;
    m = bw ? 32'h000000FF : 32'hFFFFFFFF;
    g = 0;
    ext_slow = slow;
    ext_rd = rd;
    ext_byte = bw;
    wait_len = wl;
    r = rnd();
    ext_addr = r[23:0];
    ext_wdata = rnd();
    ext_req = 1'b1;
    while (ext_busy !== 1'b1 && g < 20) begin
      tick(1);
      g++;
    end
    ext_req = 1'b0;
    while (ext_done !== 1'b1 && g < 200) begin
      tick(1);
      g++;
    end
    check({31'h0, ext_done}, 32'h1);
    if (rd) check(ext_rdata & m, exp_ext(ext_addr) & m);
    else check(wr_word & m, ext_wdata & m);
    tick(2);
  endtask

  task automatic dma_run(input logic [1:0] spd, input logic rd, input logic [15:0] cnt, want);
    int          n, idle, g;
    logic [15:0] wr0, tc0;
    n = 0;
    idle = 0;
    g = 0;
    wr0 = wr_cnt;
    tc0 = tc_cnt;
    dma_speed = spd;
    dma_rd = rd;
    dma_count = cnt;
    words = want;
    tx_data = rnd();
    dma_start = 1'b1;
    card_start = 1'b1;
    dma_en = 1'b1;
    tick(1);
    dma_start = 1'b0;
    card_start = 1'b0;
    // reader stalls: the fifo must refuse past its depth
    if (cnt > `EBI_FIFO_DEPTH) begin
      tick(300);
      check({16'h0, acks}, `EBI_FIFO_DEPTH);
    end
    while (idle < 8 && g < 5000) begin
      g++;
      if (rd && rx_valid === 1'b1) begin
        check(rx_data, exp_dma(n[15:0]));
        n++;
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
        tick(2);
      end else tick(1);
      idle = (dma_active === 1'b1 || rx_valid === 1'b1) ? 0 : idle + 1;
    end
    dma_en = 1'b0;
    check({16'h0, acks}, {16'h0, cnt});
    check({16'h0, tc_cnt - tc0}, 32'h1);
    if (rd) check(n, {16'h0, cnt});
    else begin
      check(wr_word, tx_data);
      check({16'h0, wr_cnt - wr0}, {16'h0, cnt});
    end
    tick(3);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h0000000D;
    {ext_req, ext_rd, ext_byte, ext_slow, dma_en, dma_rd, dma_start, rx_ready} = 8'h00;
    {card_start, dma_speed, wait_len, dma_count, words} = 39'h0;
    {ext_addr, ext_wdata, tx_data, last_bus} = 120'h0;
    {miscompares, comparisons, cycles} = 96'h0;
    rst_n = 1'b0;
    tick(5);
    check({26'h0, sel_n, rd_n, wr_n, ack_n, tc, qual}, 32'h0000003D);
    check(host_oe, 32'hFFFFFFFF);
    tick(5);
    rst_n = 1'b1;
    // every speed, direction and width, with and without a stretch
    for (int i = 0; i < 16; i++) ext_cycle(i[0], i[1], i[2], i[3] ? 4'h3 : 4'h0);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      dma_run(i[1:0], i[2], {14'h0, r[1:0]} + 16'h1, {14'h0, r[1:0]} + {15'h0, r[2]} + 16'h1);
    end
    dma_run(2'h3, 1'b1, 16'h000A, 16'h000A);
    results();
  end
endmodule
`default_nettype wire
